// ==== hdl/dpa_host.v ====
// Purpose: host-side port controller for one port of an asynchronous two-port memory
// Assumes: busy_n and data inputs are synchronous to sys_clk
// Notes:   one request at a time; semaphore reads report the flag taken when bit 0 of the data bus is zero
`timescale 1ns/10ps
`default_nettype none
`include "dpa_map.vh"

// Function
// - Address changes only while write strobe and port select are both high.
// - With output enable low, strobe lasts the larger of pulse or turn-around.
// - Array uses select low flag high; semaphore the reverse, held whole write.
// - Earlier port wins only with address and select settled 5 ns sooner.
// - Writing host keeps strobe low a hold time after busy deasserts.
// - Slave busy input must be low no later than the strobe falling.
module dpa_host (
    input  wire                    sys_clk,
    input  wire                    rst,
    input  wire                    req_valid,
    output wire                    req_ready,
    input  wire                    req_write,
    input  wire                    req_flag,
    input  wire                    req_oe_low_write,
    input  wire [`DPA_ADDR_W-1:0]  req_addr,
    input  wire [`DPA_DATA_W-1:0]  req_wdata,
    output reg                     rsp_valid,
    output reg  [`DPA_DATA_W-1:0]  rsp_rdata,
    output reg                     rsp_flag_taken,
    output reg  [`DPA_ADDR_W-1:0]  mem_addr,
    output reg                     port_select_n,
    output reg                     flag_select_n,
    output reg                     write_strobe_n,
    output reg                     output_enable_n,
    output reg  [`DPA_DATA_W-1:0]  data_out,
    output reg                     data_oe,
    input  wire [`DPA_DATA_W-1:0]  data_in,
    input  wire                    busy_n
);
    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_SETUP  = 3'd1;
    localparam [2:0] ST_STROBE = 3'd2;
    localparam [2:0] ST_BLOCK  = 3'd3;
    localparam [2:0] ST_HOLD   = 3'd4;
    localparam [2:0] ST_READ   = 3'd5;
    localparam [2:0] ST_END    = 3'd6;

    // counts are worked out as integers, then cut to the counter width
    localparam integer WP_INT   = `DPA_WP_CYC;
    localparam integer WZOW_INT = `DPA_WZ_OW_CYC;
    localparam integer WH_INT   = `DPA_WH_CYC;
    localparam integer APS_INT  = `DPA_APS_CYC;
    localparam integer SAA_INT  = `DPA_SAA_CYC;
    localparam integer SWRD_INT = `DPA_SWRD_CYC;

    localparam [`DPA_CNT_W-1:0] WP_CYC   = WP_INT[`DPA_CNT_W-1:0];
    localparam [`DPA_CNT_W-1:0] WZOW_CYC = WZOW_INT[`DPA_CNT_W-1:0];
    localparam [`DPA_CNT_W-1:0] WH_CYC   = WH_INT[`DPA_CNT_W-1:0];
    localparam [`DPA_CNT_W-1:0] APS_CYC  = APS_INT[`DPA_CNT_W-1:0];
    localparam [`DPA_CNT_W-1:0] SAA_CYC  = SAA_INT[`DPA_CNT_W-1:0];
    localparam [`DPA_CNT_W-1:0] SWRD_CYC = SWRD_INT[`DPA_CNT_W-1:0];

    reg  [2:0]             state;
    reg  [2:0]             next_state;
    reg                    cur_write;
    reg                    cur_flag;
    reg                    cur_oe_low;
    reg                    wait_load;
    reg  [`DPA_CNT_W-1:0]  wait_count;
    wire                   wait_done;
    wire [`DPA_CNT_W-1:0]  strobe_cyc;

    // longer of plain pulse and driver turn-around when output enable is low
    assign strobe_cyc = (cur_oe_low && (WZOW_CYC > WP_CYC)) ? WZOW_CYC : WP_CYC;

    dpa_wait u_wait (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (wait_load),
        .count   (wait_count),
        .done    (wait_done)
    );

    assign req_ready = (state == ST_IDLE);

    always @* begin
        next_state = state;
        wait_load  = 1'b0;
        wait_count = {`DPA_CNT_W{1'b0}};
        case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    next_state = ST_SETUP;
                    wait_load  = 1'b1;
                    wait_count = APS_CYC;
                end
            end
            ST_SETUP: begin
                if (wait_done) begin
                    wait_load = 1'b1;
                    if (cur_write) begin
                        next_state = ST_STROBE;
                        wait_count = strobe_cyc;
                    end else begin
                        next_state = ST_READ;
                        wait_count = SAA_CYC;
                    end
                end
            end
            ST_STROBE: begin
                // busy seen with the strobe low means the write was inhibited
                if (!busy_n) begin
                    next_state = ST_BLOCK;
                end else if (wait_done) begin
                    next_state = ST_END;
                    wait_load  = 1'b1;
                    wait_count = SWRD_CYC;
                end
            end
            ST_BLOCK: begin
                if (busy_n) begin
                    next_state = ST_HOLD;
                    wait_load  = 1'b1;
                    wait_count = WH_CYC;
                end
            end
            ST_HOLD: begin
                if (!busy_n) begin
                    next_state = ST_BLOCK;
                end else if (wait_done) begin
                    next_state = ST_END;
                    wait_load  = 1'b1;
                    wait_count = SWRD_CYC;
                end
            end
            ST_READ: begin
                // hold off while busy so data after release has settled
                if (!busy_n) begin
                    wait_load  = 1'b1;
                    wait_count = SAA_CYC;
                end else if (wait_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_END: begin
                if (wait_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state           <= ST_IDLE;
            cur_write       <= 1'b0;
            cur_flag        <= 1'b0;
            cur_oe_low      <= 1'b0;
            mem_addr        <= {`DPA_ADDR_W{1'b0}};
            port_select_n   <= 1'b1;
            flag_select_n   <= 1'b1;
            write_strobe_n  <= 1'b1;
            output_enable_n <= 1'b1;
            data_out        <= {`DPA_DATA_W{1'b0}};
            data_oe         <= 1'b0;
            rsp_valid       <= 1'b0;
            rsp_rdata       <= {`DPA_DATA_W{1'b0}};
            rsp_flag_taken  <= 1'b0;
        end else begin
            state     <= next_state;
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        // strobes still high here, so the address may move
                        cur_write       <= req_write;
                        cur_flag        <= req_flag;
                        cur_oe_low      <= req_oe_low_write;
                        mem_addr        <= req_addr;
                        // array: select low, flag high; semaphore: the reverse
                        port_select_n   <= req_flag;
                        flag_select_n   <= ~req_flag;
                        output_enable_n <= req_write ? ~req_oe_low_write : 1'b0;
                        data_out        <= req_wdata;
                        data_oe         <= 1'b0;
                    end
                end
                ST_SETUP: begin
                    if (wait_done && cur_write) begin
                        // selects already low, strobe falls after: overlap
                        write_strobe_n <= 1'b0;
                        data_oe        <= 1'b1;
                    end
                end
                ST_STROBE, ST_BLOCK, ST_HOLD: begin
                    if (next_state == ST_END) begin
                        write_strobe_n  <= 1'b1;
                        port_select_n   <= 1'b1;
                        flag_select_n   <= 1'b1;
                        output_enable_n <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (next_state == ST_IDLE) begin
                        rsp_valid       <= 1'b1;
                        rsp_rdata       <= data_in;
                        // flag is held when bit 0 reads zero
                        rsp_flag_taken  <= cur_flag & ~data_in[0];
                        port_select_n   <= 1'b1;
                        flag_select_n   <= 1'b1;
                        output_enable_n <= 1'b1;
                    end
                end
                ST_END: begin
                    if (wait_done) begin
                        data_oe   <= 1'b0;
                        rsp_valid <= 1'b1;
                    end
                end
                default: begin
                    data_oe <= 1'b0;
                end
            endcase
        end
    end
endmodule // dpa_host
`default_nettype wire

// ==== hdl/dpa_map.vh ====
// Purpose: timing counts and field constants for the two-port memory host controller
// Assumes: sys_clk at 250 MHz (4 ns period)
// Notes:   least times and longest times both round up, none below one cycle
`ifndef DPA_MAP_VH
`define DPA_MAP_VH

`define DPA_CLK_NS        4
`define DPA_ADDR_W        14
`define DPA_DATA_W        8
// write pulse least time, slowest grade
`define DPA_WP_NS         40
`define DPA_WP_CYC        ((`DPA_WP_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
// output turn-off plus turn-on when output enable is low
`define DPA_WZ_OW_NS      25
`define DPA_WZ_OW_CYC     ((`DPA_WZ_OW_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
// hold of write strobe after busy release, slowest grade
`define DPA_WH_NS         25
`define DPA_WH_CYC        ((`DPA_WH_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
// arbitration priority setup before the other port
`define DPA_APS_NS        5
`define DPA_APS_CYC       ((`DPA_APS_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
// busy sample delay after address/select, slowest busy access
`define DPA_BAA_NS        45
`define DPA_BAA_CYC       ((`DPA_BAA_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
// read access for semaphore read-back
`define DPA_SAA_NS        55
`define DPA_SAA_CYC       ((`DPA_SAA_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
// semaphore write to read spacing
`define DPA_SWRD_NS       5
`define DPA_SWRD_CYC      ((`DPA_SWRD_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_CNT_W         5
`define DPA_FLAG_FREE     8'hFF

`endif

// ==== hdl/dpa_wait.v ====
// Purpose: down-counter that times one phase of a pin sequence
// Assumes: load and count values fit the counter width
// Notes:   done is high while the count is zero
`timescale 1ns/10ps
`default_nettype none
`include "dpa_map.vh"

module dpa_wait (
    input  wire                    sys_clk,
    input  wire                    rst,
    input  wire                    load,
    input  wire [`DPA_CNT_W-1:0]   count,
    output wire                    done
);
    reg [`DPA_CNT_W-1:0] remain;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            remain <= {`DPA_CNT_W{1'b0}};
        end else if (load) begin
            remain <= count;
        end else if (remain != {`DPA_CNT_W{1'b0}}) begin
            remain <= remain - {{(`DPA_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (remain == {`DPA_CNT_W{1'b0}});
endmodule // dpa_wait
`default_nettype wire

// ==== verification/dpa_dev_model.sv ====
// Purpose: one port of the two-port memory as the host controller sees it
// Assumes: pins move just after sys_clk rising edges
// Notes:   contend plays the opposite port at the same address
`timescale 1ns/10ps
`default_nettype none
`include "dpa_map.vh"
module dpa_dev_model (
    input  wire logic                   sys_clk,
    input  wire logic [`DPA_ADDR_W-1:0] mem_addr,
    input  wire logic                   port_select_n,
    input  wire logic                   flag_select_n,
    input  wire logic                   write_strobe_n,
    input  wire logic                   output_enable_n,
    input  wire logic [`DPA_DATA_W-1:0] data_out,
    input  wire logic                   data_oe,
    input  wire logic                   contend,
    input  wire logic                   sem_other,
    output var  logic [`DPA_DATA_W-1:0] data_in,
    output var  logic                   busy_n
);
    logic [`DPA_DATA_W-1:0] mem [0:(1<<`DPA_ADDR_W)-1];
    logic                   sem_mine = 1'b0;
    logic [`DPA_DATA_W-1:0] last     = 8'h00;
    logic                   drive;
    // master role, only this port can lose
    assign busy_n = !(contend && !port_select_n);
    assign drive  = !output_enable_n && write_strobe_n && !(port_select_n && flag_select_n);
    // released bus shows the inverse of the last value
    always_comb begin
        if (!drive)
            data_in = ~last;
        else if (!flag_select_n)
            data_in = {`DPA_DATA_W{~sem_mine}};
        else
            data_in = mem[mem_addr];
    end
    always @(posedge sys_clk) begin
        if (drive)
            last <= data_in;
        if (!write_strobe_n && busy_n && data_oe) begin
            if (!port_select_n)
                mem[mem_addr] <= data_out;
            else if (!flag_select_n)
                sem_mine <= !data_out[0] && (sem_mine || !sem_other);
        end
    end
endmodule // dpa_dev_model
`default_nettype wire

// ==== verification/dpa_host_chk.sv ====
// Purpose: pin sequence checks on the host port controller
// Assumes: one sys_clk domain, rst active high
// Notes:   bound to dpa_host below
`timescale 1ns/10ps
`default_nettype none
`include "dpa_map.vh"
module dpa_host_chk (
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   rsp_valid,
    input wire logic [`DPA_ADDR_W-1:0] mem_addr,
    input wire logic                   port_select_n,
    input wire logic                   flag_select_n,
    input wire logic                   write_strobe_n,
    input wire logic                   data_oe,
    input wire logic                   busy_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [`DPA_CNT_W-1:0] low_cnt;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            low_cnt <= '0;
        else if (write_strobe_n)
            low_cnt <= '0;
        else if (low_cnt != '1)
            low_cnt <= low_cnt + 1'b1;
    end
    a_addr_when_idle: assert property ($changed(mem_addr) |-> write_strobe_n && $past(write_strobe_n))
        else $error("address moved with strobe low");
    a_strobe_has_sel: assert property (!write_strobe_n |-> data_oe && (port_select_n != flag_select_n))
        else $error("strobe low without one select and data");
    a_sel_one_only: assert property (port_select_n || flag_select_n)
        else $error("both selects low");
    a_sel_held: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(port_select_n) && $stable(flag_select_n))
        else $error("select moved inside write");
    a_pulse_min: assert property ($rose(write_strobe_n) |-> low_cnt >= `DPA_WP_CYC)
        else $error("write pulse too short");
    a_setup_first: assert property ($fell(write_strobe_n) |-> !($past(port_select_n) && $past(flag_select_n)) && $stable(mem_addr))
        else $error("select not settled before strobe");
    a_busy_blocks: assert property (!busy_n && !write_strobe_n |=> !write_strobe_n)
        else $error("strobe released while busy");
    a_hold_after: assert property ($rose(busy_n) && !write_strobe_n |-> !write_strobe_n [*7])
        else $error("strobe hold after busy too short");
    a_busy_no_rsp: assert property (!busy_n && !write_strobe_n |=> !rsp_valid)
        else $error("write finished while busy");
    c_array_write: cover property ($rose(write_strobe_n) && !port_select_n);
    c_flag_write: cover property ($rose(write_strobe_n) && !flag_select_n);
    c_busy_stall: cover property (!busy_n && !write_strobe_n);
endmodule // dpa_host_chk
bind dpa_host dpa_host_chk dpa_host_chk_inst (.sys_clk, .rst, .rsp_valid, .mem_addr,
    .port_select_n, .flag_select_n, .write_strobe_n, .data_oe, .busy_n);
`default_nettype wire

// ==== verification/tb_dpa_host.sv ====
// Purpose: self-checking bench of the host port controller
// Assumes: device model answers at once
// Notes:   contend and sem_other stand for the opposite port
`timescale 1ns/10ps
`default_nettype none
`include "dpa_map.vh"
module tb_dpa_host;
    logic                   sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic                   req_flag = 1'b0, req_oe_low_write = 1'b0, contend = 1'b0;
    logic                   sem_other = 1'b0, req_ready, rsp_valid, taken, port_select_n;
    logic                   flag_select_n, write_strobe_n, output_enable_n, data_oe, busy_n;
    logic [`DPA_ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [`DPA_DATA_W-1:0] req_wdata = '0, data_in, data_out, rdata;
    int                     err_count = 0, n_tests = 0, lat;
    always #2 sys_clk = ~sys_clk;
    dpa_host dpa_host_inst (.sys_clk, .rst, .req_valid, .req_ready, .req_write, .req_flag,
        .req_oe_low_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata(rdata),
        .rsp_flag_taken(taken), .mem_addr, .port_select_n, .flag_select_n, .write_strobe_n,
        .output_enable_n, .data_out, .data_oe, .data_in, .busy_n);
    dpa_dev_model dpa_dev_model_inst (.sys_clk, .mem_addr, .port_select_n, .flag_select_n,
        .write_strobe_n, .output_enable_n, .data_out, .data_oe, .contend, .sem_other,
        .data_in, .busy_n);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic wr, fl, oel, input logic [13:0] a, input logic [7:0] d);
        check({7'h00, req_ready}, 8'h01);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_flag <= fl;
        req_oe_low_write <= oel;
        req_addr <= a;
        req_wdata <= d;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(negedge sys_clk);
        check({7'h00, req_ready}, 8'h00);
        lat = 1;
        do begin
            @(negedge sys_clk);
            lat++;
        end while (rsp_valid !== 1'b1 && lat < 300);
        check({7'h00, rsp_valid}, 8'h01);
    endtask
    task automatic t_array();
        access(1'b1, 1'b0, 1'b0, 14'h3fff, 8'ha5);
        access(1'b1, 1'b0, 1'b1, 14'h0000, 8'h5a);
        access(1'b0, 1'b0, 1'b0, 14'h3fff, 8'h00);
        check(rdata, 8'ha5);
        access(1'b0, 1'b0, 1'b0, 14'h0000, 8'h00);
        check(rdata, 8'h5a);
    endtask
    task automatic t_sem();
        access(1'b0, 1'b1, 1'b0, 14'h0003, 8'h00);
        check({7'h00, taken}, 8'h00);
        check(rdata, 8'hff);
        access(1'b1, 1'b1, 1'b0, 14'h0003, 8'h00);
        access(1'b0, 1'b1, 1'b0, 14'h0003, 8'h00);
        check({7'h00, taken}, 8'h01);
        check(rdata, 8'h00);
        access(1'b1, 1'b1, 1'b0, 14'h0003, 8'h01);
        sem_other <= 1'b1;
        access(1'b1, 1'b1, 1'b0, 14'h0003, 8'h00);
        access(1'b0, 1'b1, 1'b0, 14'h0003, 8'h00);
        check({7'h00, taken}, 8'h00);
        sem_other <= 1'b0;
    endtask
    task automatic t_busy();
        contend <= 1'b1;
        fork
            access(1'b1, 1'b0, 1'b0, 14'h1234, 8'hc3);
            begin
                repeat (25) @(posedge sys_clk);
                contend <= 1'b0;
            end
        join
        check({7'h00, lat > 25}, 8'h01);
        access(1'b0, 1'b0, 1'b0, 14'h1234, 8'h00);
        check(rdata, 8'hc3);
        contend <= 1'b1;
        fork
            access(1'b0, 1'b0, 1'b0, 14'h1234, 8'h00);
            begin
                repeat (25) @(posedge sys_clk);
                contend <= 1'b0;
            end
        join
        check({7'h00, lat > 25}, 8'h01);
        check(rdata, 8'hc3);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_array();
        t_sem();
        t_busy();
        finish_test();
    end
    initial begin
        #40000;
        err_count++;
        finish_test();
    end
endmodule // tb_dpa_host
`default_nettype wire
